// ==== include/pspc_pkg.sv ====
// Package for the pulse sequence playback controller: register map,
// field layouts, command codes, modes and timing constants.
// Assumes a 32-bit classic Wishbone slave port and a 100 MHz sample clock.
package pspc_pkg;

  // Register byte offsets
  localparam logic [7:0] pspc_reg_ctrl     = 8'h00; // Trigger setup
  localparam logic [7:0] pspc_reg_cmd      = 8'h04; // Write-only commands
  localparam logic [7:0] pspc_reg_status   = 8'h08; // Read-only status
  localparam logic [7:0] pspc_reg_runs     = 8'h0c; // Run count, signed
  localparam logic [7:0] pspc_reg_final    = 8'h10; // Final state
  localparam logic [7:0] pspc_reg_const    = 8'h14; // Constant state
  localparam logic [7:0] pspc_reg_step_len = 8'h18; // Step count on commit
  localparam logic [7:0] pspc_reg_wr_idx   = 8'h1c; // Step write index
  localparam logic [7:0] pspc_reg_wr_dur   = 8'h20; // Step duration, ns
  localparam logic [7:0] pspc_reg_wr_lvl   = 8'h24; // Step levels, writes

  // Control register fields
  localparam int pspc_ctrl_start_lsb = 0;  // 3-bit start selection
  localparam int pspc_ctrl_rearm_bit = 4;  // 1 = rearm by command

  // Command register bits
  localparam int pspc_cmd_reset   = 0;
  localparam int pspc_cmd_launch  = 1;
  localparam int pspc_cmd_rearm   = 2;
  localparam int pspc_cmd_abort   = 3;
  localparam int pspc_cmd_const   = 4;
  localparam int pspc_cmd_commit  = 5;

  // Status register bits
  localparam int pspc_st_loaded   = 0;
  localparam int pspc_st_active   = 1;
  localparam int pspc_st_done     = 2;
  localparam int pspc_st_rearm_ok = 3;

  // Level word layout: digital in [7:0], analog 0 in [19:8], analog 1 [31:20]
  localparam int pspc_lvl_dig_lsb = 0;
  localparam int pspc_lvl_a0_lsb  = 8;
  localparam int pspc_lvl_a1_lsb  = 20;
  localparam int pspc_dig_w       = 8;
  localparam int pspc_ana_w       = 12;
  localparam int pspc_lvl_w       = 32;

  localparam logic [31:0] pspc_zero_state = 32'h0000_0000;
  localparam logic [31:0] pspc_runs_inf   = 32'hffff_ffff;

  typedef enum logic [2:0] {
    pspc_start_on_upload,
    pspc_start_software,
    pspc_start_rising,
    pspc_start_falling,
    pspc_start_both
  } pspc_start_type;

  // Playback chunk and clock
  localparam int pspc_chunk_ns   = 8;
  localparam int pspc_clk_ns     = 10;
  localparam int pspc_chunk_cyc  =
    (pspc_chunk_ns + pspc_clk_ns - 1) / pspc_clk_ns;

endpackage

// ==== src/pspc_ctrl.sv ====
// Pulse sequence playback controller: step memory, run counter, trigger
// selection, constant and final states, Wishbone register slave.
// Assumes trig_i is asynchronous; one 100 MHz clock; classic Wishbone.
//
// Functional notes
// - Reset command zeros outputs, defaults, automatic rearm
// - Default start plays right after upload
// - Constant command stops playback, holds given state
// - After constant, no retrigger of old sequence
// - After requested runs, hold final state
// - Negative run count repeats forever
// - Empty sequence applies final state at once
// - Step holds duration, digital set, two analogs
// - External start on rising, falling or both
// - Automatic rearm restarts on later trigger
// - Manual rearm command after finish, reports success
// - Upload start: launch after finish replays
// - Software start launches; manual rearm once only
// - Edge start ignores software launch command
// - Abort ends playback; final state unchanged if resting
// - Abort without final uses last constant state
// - Report whether memory holds a sequence
// - Active flag true only while playing
// - Done flag true while resting after finish
// - Start selection and rearm method read back
// - Playback rounds total length to whole chunks
`timescale 1ns/1ps
module pspc_ctrl #(
  parameter int depth = 64
) (
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          trig_i,
  output logic      [pspc_pkg::pspc_dig_w-1:0] dig_o,
  output logic      [pspc_pkg::pspc_ana_w-1:0] ana0_o,
  output logic      [pspc_pkg::pspc_ana_w-1:0] ana1_o,
  output logic                               playback_done_evt_o
);

  localparam int aw = $clog2(depth);

  if (depth < 2 || depth > 65536 || (depth & (depth - 1)) != 0) begin : g_chk
    $error("pspc_ctrl: depth must be a power of two from 2 to 65536");
  end

  typedef enum logic [1:0] {
    pspc_idle,
    pspc_play,
    pspc_pad,
    pspc_rest
  } pspc_mode_type;

  typedef struct packed {
    logic [31:0]                wb_dat;
    logic                       wb_ack;
    logic [2:0]                 trig_sync;
    logic                       trig_state;
    logic [2:0]                 start_sel;
    logic                       rearm_by_command;
    logic                       armed;
    logic                       memory_loaded_flag;
    logic                       stale;
    logic                       has_final;
    logic                       rearm_ok;
    logic [aw:0]                step_len;
    logic [aw-1:0]              wr_idx;
    logic [31:0]                wr_dur;
    logic [31:0]                runs;
    logic [31:0]                runs_left;
    logic [31:0]                final_state;
    logic [31:0]                const_state;
    logic [31:0]                out_state;
    logic [aw:0]                step;
    logic [31:0]                step_cnt;
    logic                       done_evt;
    pspc_mode_type              mode;
  } pspc_state_type;

  pspc_state_type q;
  pspc_state_type next_q;

  // Step memory: duration and level word per step
  logic [31:0] mem_dur [depth];
  logic [31:0] mem_lvl [depth];
  logic        mem_we;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_dur[q.wr_idx] <= q.wr_dur;
      mem_lvl[q.wr_idx] <= wb_dat_i;
    end
  end

  logic        req;
  logic        wr;
  logic        edge_rise;
  logic        edge_fall;
  logic        trig_evt;
  logic        launch;
  logic [31:0] status;

  assign req = wb_cyc_i && wb_stb_i && !q.wb_ack;
  assign wr  = req && wb_we_i && (&wb_sel_i);
  assign mem_we = wr && hit(wb_adr_i, pspc_pkg::pspc_reg_wr_lvl);
  // A change counts once the second and third stages agree
  assign edge_rise = (q.trig_sync[2] == q.trig_sync[1]) && q.trig_sync[1]
                     && !q.trig_state;
  assign edge_fall = (q.trig_sync[2] == q.trig_sync[1]) && !q.trig_sync[1]
                     && q.trig_state;

  always_comb begin
    status = '0;
    status[pspc_pkg::pspc_st_loaded]   = q.memory_loaded_flag;
    status[pspc_pkg::pspc_st_active]   = q.mode inside {pspc_play, pspc_pad};
    status[pspc_pkg::pspc_st_done]     = (q.mode == pspc_rest);
    status[pspc_pkg::pspc_st_rearm_ok] = q.rearm_ok;
  end

  always_comb begin
    next_q = q;
    next_q.wb_ack = req;
    next_q.done_evt = 1'b0;
    next_q.trig_sync = {q.trig_sync[1:0], trig_i};
    if (edge_rise || edge_fall) begin
      next_q.trig_state = q.trig_sync[1];
    end
    trig_evt = 1'b0;
    case (pspc_pkg::pspc_start_type'(q.start_sel))
      pspc_pkg::pspc_start_rising:  trig_evt = edge_rise;
      pspc_pkg::pspc_start_falling: trig_evt = edge_fall;
      pspc_pkg::pspc_start_both:    trig_evt = edge_rise || edge_fall;
      default:                      trig_evt = 1'b0;
    endcase
    launch = trig_evt && (q.armed || !q.rearm_by_command);

    // Read data
    if (req && !wb_we_i) begin
      if (hit(wb_adr_i, pspc_pkg::pspc_reg_ctrl)) begin
        next_q.wb_dat = '0;
        next_q.wb_dat[pspc_pkg::pspc_ctrl_start_lsb +: 3] = q.start_sel;
        next_q.wb_dat[pspc_pkg::pspc_ctrl_rearm_bit] =
          q.rearm_by_command;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_status)) begin
        next_q.wb_dat = status;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_runs)) begin
        next_q.wb_dat = q.runs;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_final)) begin
        next_q.wb_dat = q.final_state;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_const)) begin
        next_q.wb_dat = q.const_state;
      end else begin
        next_q.wb_dat = '0;
      end
    end

    // Writes
    if (wr) begin
      if (hit(wb_adr_i, pspc_pkg::pspc_reg_ctrl)) begin
        next_q.start_sel = wb_dat_i[pspc_pkg::pspc_ctrl_start_lsb +: 3];
        next_q.rearm_by_command = wb_dat_i[pspc_pkg::pspc_ctrl_rearm_bit];
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_runs)) begin
        next_q.runs = wb_dat_i;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_final)) begin
        next_q.final_state = wb_dat_i;
        next_q.has_final = 1'b1;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_const)) begin
        next_q.const_state = wb_dat_i;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_step_len)) begin
        next_q.step_len = wb_dat_i[aw:0];
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_wr_idx)) begin
        next_q.wr_idx = wb_dat_i[aw-1:0];
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_wr_dur)) begin
        next_q.wr_dur = wb_dat_i;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_wr_lvl)) begin
        next_q.wr_idx = q.wr_idx + 1'b1;
      end else if (hit(wb_adr_i, pspc_pkg::pspc_reg_cmd)) begin
        if (wb_dat_i[pspc_pkg::pspc_cmd_launch]) begin
          case (pspc_pkg::pspc_start_type'(q.start_sel))
            pspc_pkg::pspc_start_on_upload:
              // Replays only a finished, finite sequence
              launch = q.mode == pspc_rest && !q.runs[31];
            pspc_pkg::pspc_start_software:
              launch = q.armed || !q.rearm_by_command;
            default: ;
          endcase
        end
        if (wb_dat_i[pspc_pkg::pspc_cmd_rearm]) begin
          next_q.rearm_ok = q.rearm_by_command && q.mode == pspc_rest
                            && !q.stale;
          if (next_q.rearm_ok) begin
            next_q.armed = 1'b1;
          end
        end
        if (wb_dat_i[pspc_pkg::pspc_cmd_commit]) begin
          next_q.memory_loaded_flag = 1'b1;
          next_q.stale = 1'b0;
          next_q.armed = 1'b1;
          if (q.start_sel == 3'(pspc_pkg::pspc_start_on_upload)) begin
            launch = 1'b1;
          end else begin
            next_q.mode = pspc_idle;
          end
        end
      end
    end

    // A commit in this cycle already counts as loaded and fresh
    launch = launch && next_q.memory_loaded_flag && !next_q.stale;

    // Sequencer
    case (q.mode)
      pspc_play: begin
        if (q.step_cnt > 32'(pspc_pkg::pspc_clk_ns)) begin
          next_q.step_cnt = q.step_cnt - 32'(pspc_pkg::pspc_clk_ns);
        end else if (q.step + 1'b1 < q.step_len) begin
          next_q.step = q.step + 1'b1;
          next_q.step_cnt = mem_dur[q.step[aw-1:0] + 1'b1];
          next_q.out_state = mem_lvl[q.step[aw-1:0] + 1'b1];
        end else begin
          next_q.mode = pspc_pad;
        end
      end
      pspc_pad: begin
        // Complete the last chunk before another run or the final state
        if (q.runs_left > 32'd1 || q.runs[31]) begin
          next_q.runs_left = q.runs_left - 32'd1;
          next_q.mode = pspc_play;
          next_q.step = '0;
          next_q.step_cnt = mem_dur[0];
          next_q.out_state = mem_lvl[0];
        end else begin
          next_q.mode = pspc_rest;
          next_q.out_state = q.has_final ? q.final_state : q.const_state;
          next_q.done_evt = 1'b1;
          if (q.rearm_by_command) begin
            next_q.armed = 1'b0;
          end
        end
      end
      default: ;
    endcase

    if (launch) begin
      next_q.runs_left = q.runs;
      if (q.step_len == '0 || q.runs == '0) begin
        next_q.mode = pspc_rest;
        next_q.out_state = q.has_final ? q.final_state : q.const_state;
        next_q.done_evt = 1'b1;
      end else begin
        next_q.mode = pspc_play;
        next_q.step = '0;
        next_q.step_cnt = mem_dur[0];
        next_q.out_state = mem_lvl[0];
      end
      if (q.rearm_by_command) begin
        next_q.armed = 1'b0;
      end
    end

    if (wr && hit(wb_adr_i, pspc_pkg::pspc_reg_cmd)) begin
      if (wb_dat_i[pspc_pkg::pspc_cmd_abort] &&
          (q.mode == pspc_play || q.mode == pspc_pad)) begin
        next_q.mode = pspc_rest;
        next_q.out_state = q.has_final ? q.final_state
                                       : q.const_state;
        next_q.done_evt = 1'b1;
      end
      if (wb_dat_i[pspc_pkg::pspc_cmd_const]) begin
        next_q.mode = pspc_idle;
        next_q.out_state = q.const_state;
        next_q.stale = 1'b1;
        next_q.done_evt = 1'b0;
      end
      if (wb_dat_i[pspc_pkg::pspc_cmd_reset]) begin
        next_q.mode = pspc_idle;
        next_q.out_state = pspc_pkg::pspc_zero_state;
        next_q.const_state = pspc_pkg::pspc_zero_state;
        next_q.final_state = pspc_pkg::pspc_zero_state;
        next_q.start_sel = 3'(pspc_pkg::pspc_start_on_upload);
        next_q.rearm_by_command = 1'b0;
        next_q.runs = pspc_pkg::pspc_runs_inf;
        next_q.has_final = 1'b0;
        next_q.stale = 1'b1;
        next_q.done_evt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{wb_dat: '0, wb_ack: 1'b0, trig_sync: '0, trig_state: 1'b0,
             start_sel: 3'(pspc_pkg::pspc_start_on_upload),
             rearm_by_command: 1'b0, armed: 1'b0,
             memory_loaded_flag: 1'b0, stale: 1'b0, has_final: 1'b0,
             rearm_ok: 1'b0, step_len: '0, wr_idx: '0, wr_dur: '0,
             runs: pspc_pkg::pspc_runs_inf, runs_left: '0,
             final_state: pspc_pkg::pspc_zero_state,
             const_state: pspc_pkg::pspc_zero_state,
             out_state: pspc_pkg::pspc_zero_state, step: '0,
             step_cnt: '0, done_evt: 1'b0,
             mode: pspc_idle};
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.wb_ack;
  assign dig_o  = q.out_state[pspc_pkg::pspc_lvl_dig_lsb +:
                              pspc_pkg::pspc_dig_w];
  assign ana0_o = q.out_state[pspc_pkg::pspc_lvl_a0_lsb +:
                              pspc_pkg::pspc_ana_w];
  assign ana1_o = q.out_state[pspc_pkg::pspc_lvl_a1_lsb +:
                              pspc_pkg::pspc_ana_w];
  assign playback_done_evt_o = q.done_evt;

  // Assertions
  property p_done_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      q.done_evt |=> !q.done_evt;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion event longer than one cycle");

  property p_done_rest;
    @(posedge clk_i) disable iff (sys_rst_i)
      q.done_evt |-> q.mode == pspc_rest;
  endproperty
  a_done_rest: assert property (p_done_rest)
    else $error("completion event outside final state");

  property p_const_stops;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr && hit(wb_adr_i, pspc_pkg::pspc_reg_cmd) &&
       wb_dat_i[pspc_pkg::pspc_cmd_const] &&
       !wb_dat_i[pspc_pkg::pspc_cmd_reset])
      |=> q.mode == pspc_idle && q.out_state == $past(q.const_state);
  endproperty
  a_const_stops: assert property (p_const_stops)
    else $error("constant command did not stop playback");

  property p_stale_no_play;
    @(posedge clk_i) disable iff (sys_rst_i)
      q.stale && next_q.stale |=> q.mode != pspc_play;
  endproperty
  a_stale_no_play: assert property (p_stale_no_play)
    else $error("old sequence retriggered after constant");

  property p_ext_ignores_sw;
    @(posedge clk_i) disable iff (sys_rst_i)
      (q.mode == pspc_rest && q.start_sel >= 3'd2 && !trig_evt &&
       wr && wb_dat_i == 32'h0000_0002 &&
       hit(wb_adr_i, pspc_pkg::pspc_reg_cmd)) |=> q.mode == pspc_rest;
  endproperty
  a_ext_ignores_sw: assert property (p_ext_ignores_sw)
    else $error("software launch acted in edge mode");

  property p_reset_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr && hit(wb_adr_i, pspc_pkg::pspc_reg_cmd) &&
       wb_dat_i[pspc_pkg::pspc_cmd_reset])
      |=> {ana1_o, ana0_o, dig_o} == '0 && !q.rearm_by_command;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset command left outputs or rearm set");

  property p_active_excl;
    @(posedge clk_i) disable iff (sys_rst_i)
      status[pspc_pkg::pspc_st_active] |->
        q.memory_loaded_flag && !status[pspc_pkg::pspc_st_done];
  endproperty
  a_active_excl: assert property (p_active_excl)
    else $error("active and done both set");

  property p_rest_holds;
    @(posedge clk_i) disable iff (sys_rst_i)
      q.mode == pspc_rest && !wr ##1 q.mode == pspc_rest
      |-> $stable(q.out_state);
  endproperty
  a_rest_holds: assert property (p_rest_holds)
    else $error("final state changed while resting");

endmodule // pspc_ctrl

// ==== sim/pspc_trig_src.sv ====
// External trigger source that stands in front of the trigger pin.
// Assumes the bench sets the wanted pin level just after a clock edge.
`timescale 1ns/1ps
module pspc_trig_src (
  input  wire logic clk_i,
  input  wire logic lvl_i,
  output logic      trig_o
);
  logic [1:0] dly = 2'h0;

  // Two cycles of cable delay; the pin is always driven, never floats
  always @(posedge clk_i) begin
    dly <= {dly[0], lvl_i};
  end
  assign trig_o = dly[1];
endmodule // pspc_trig_src

// ==== sim/pulse_sequence_playback_ctrl_tb.sv ====
// Self-checking bench for the playback controller.
// Assumes the package is compiled first and one 100 MHz clock.
`timescale 1ns/1ps
module pulse_sequence_playback_ctrl_tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tl = 1'b0;
  logic        strict = 1'b1, ack, evt, trig;
  logic [7:0]  adr = 8'h00, dig;
  logic [3:0]  sel = 4'h0;
  logic [11:0] a0, a1;
  logic [31:0] dat = 32'h0, rdat, seed = 32'h31, f, c, lvl, lv;
  logic [63:0] e;
  logic [63:0] rq[$];
  logic [31:0] sl[4];
  logic [31:0] evq[$];
  int          n_fail = 0;
  int          check_count = 0;

  always #5 clk_i = ~clk_i;
  assign lvl = {a1, a0, dig};

  pspc_ctrl #(.depth(4)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trig_i(trig), .dig_o(dig),
    .ana0_o(a0), .ana1_o(a1), .playback_done_evt_o(evt));
  pspc_trig_src trig_u (.clk_i(clk_i), .lvl_i(tl), .trig_o(trig));

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic wb(input logic [7:0] a, input logic [31:0] d,
                    input logic w);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      final_report();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    rq.push_back({m, x});
    wb(a, 32'h0, 1'b0);
  endtask

  task automatic cmd(input int b);
    wb(pspc_pkg::pspc_reg_cmd, 32'h1 << b, 1'b1);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] x);
    idle(3);
    cmp(lvl, x);
  endtask

  task automatic wait_ev();
    int n;
    n = 0;
    while (evq.size() != 0 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      final_report();
    end
    idle(2);
  endtask

  task automatic fire(input logic v);
    evq.push_back(f);
    tl <= v;
    wait_ev();
  endtask

  // Steps get random levels; durations 15, 25, 35 ns exercise rounding up
  task automatic up(input int n, input logic [31:0] runs,
                    input logic [31:0] fin, input logic decl);
    wb(pspc_pkg::pspc_reg_runs, runs, 1'b1);
    if (decl) wb(pspc_pkg::pspc_reg_final, fin, 1'b1);
    wb(pspc_pkg::pspc_reg_wr_idx, 32'h0, 1'b1);
    for (int i = 0; i < n; i++) begin
      wb(pspc_pkg::pspc_reg_wr_dur, 32'(10 * i + 15), 1'b1);
      sl[i] = rnd();
      wb(pspc_pkg::pspc_reg_wr_lvl, sl[i], 1'b1);
    end
    wb(pspc_pkg::pspc_reg_step_len, 32'(n), 1'b1);
    cmd(pspc_pkg::pspc_cmd_commit);
  endtask

  // Step i lasts 10*i+15 ns, so it stands i+2 clocks; call right after
  // the launching write returns, while step 0 has just been applied
  task automatic steps();
    for (int i = 0; i < 3; i++) begin
      repeat (i + 2) begin
        cmp(lvl, sl[i]);
        @(posedge clk_i);
      end
    end
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() != 0) begin
      e = rq.pop_front();
      cmp(rdat & e[63:32], e[31:0]);
    end
  end

  // A completion pulse nobody announced is a mismatch while strict is set
  always begin
    @(posedge clk_i);
    if (evt === 1'b1) begin
      if (evq.size() == 0) begin
        if (strict) cmp(32'h1, 32'h0);
      end else begin
        lv = evq.pop_front();
        @(posedge clk_i);
        cmp(lvl, lv);
      end
    end
  end

  initial begin
    idle(90000);
    n_fail++;
    final_report();
  end

  initial begin
    idle(12);
    sys_rst_i <= 1'b0;
    rd(pspc_pkg::pspc_reg_ctrl, 32'h0, 32'h17);
    rd(pspc_pkg::pspc_reg_status, 32'h0, 32'h7);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    chk(32'h0);
    $display("test defaults done");
    f = rnd();
    evq.push_back(f);
    up(3, 32'h1, f, 1'b1);
    steps();
    wait_ev();
    rd(pspc_pkg::pspc_reg_status, 32'h5, 32'h7);
    evq.push_back(f);
    cmd(pspc_pkg::pspc_cmd_launch);
    steps();
    wait_ev();
    $display("test upload start done");
    wb(pspc_pkg::pspc_reg_ctrl, 32'h11, 1'b1);
    rd(pspc_pkg::pspc_reg_ctrl, 32'h11, 32'h17);
    evq.push_back(f);
    cmd(pspc_pkg::pspc_cmd_launch);
    steps();
    wait_ev();
    cmd(pspc_pkg::pspc_cmd_launch);
    idle(60);
    cmd(pspc_pkg::pspc_cmd_rearm);
    rd(pspc_pkg::pspc_reg_status, 32'h8, 32'h8);
    evq.push_back(f);
    cmd(pspc_pkg::pspc_cmd_launch);
    wait_ev();
    $display("test software manual rearm done");
    wb(pspc_pkg::pspc_reg_ctrl, 32'h2, 1'b1);
    cmd(pspc_pkg::pspc_cmd_launch);
    idle(60);
    fire(1'b1);
    wb(pspc_pkg::pspc_reg_ctrl, 32'h3, 1'b1);
    fire(1'b0);
    tl <= 1'b1;
    idle(60);
    wb(pspc_pkg::pspc_reg_ctrl, 32'h4, 1'b1);
    fire(1'b0);
    fire(1'b1);
    $display("test trigger edges done");
    wb(pspc_pkg::pspc_reg_ctrl, 32'h0, 1'b1);
    f = rnd();
    up(2, pspc_pkg::pspc_runs_inf, f, 1'b1);
    idle(200);
    rd(pspc_pkg::pspc_reg_status, 32'h3, 32'h7);
    evq.push_back(f);
    cmd(pspc_pkg::pspc_cmd_abort);
    wait_ev();
    cmd(pspc_pkg::pspc_cmd_abort);
    chk(f);
    $display("test endless and abort done");
    up(2, pspc_pkg::pspc_runs_inf, f, 1'b1);
    c = rnd();
    wb(pspc_pkg::pspc_reg_const, c, 1'b1);
    cmd(pspc_pkg::pspc_cmd_const);
    chk(c);
    cmd(pspc_pkg::pspc_cmd_launch);
    idle(60);
    chk(c);
    wb(pspc_pkg::pspc_reg_const, pspc_pkg::pspc_zero_state, 1'b1);
    cmd(pspc_pkg::pspc_cmd_const);
    chk(32'h0);
    f = rnd();
    evq.push_back(f);
    up(0, 32'h1, f, 1'b1);
    wait_ev();
    $display("test constant and empty done");
    cmd(pspc_pkg::pspc_cmd_reset);
    chk(32'h0);
    rd(pspc_pkg::pspc_reg_ctrl, 32'h0, 32'h17);
    c = rnd();
    wb(pspc_pkg::pspc_reg_const, c, 1'b1);
    cmd(pspc_pkg::pspc_cmd_const);
    up(2, pspc_pkg::pspc_runs_inf, 32'h0, 1'b0);
    idle(20);
    // Whether an abort to the constant state pulses is left open
    strict = 1'b0;
    cmd(pspc_pkg::pspc_cmd_abort);
    chk(c);
    $display("test reset command done");
    final_report();
  end
endmodule // pulse_sequence_playback_ctrl_tb
